// ==== hdl/t2co_pkg.sv ====
// Types shared by the clock-out timer files.
// Assumes nothing beyond a SystemVerilog compiler.
package t2co_pkg;

  // ****************************************
  // Prescaler states
  // ****************************************
  typedef enum logic [1:0] {
    T2CO_PH_IDLE = 2'b01,
    T2CO_PH_RUN = 2'b10
  } t2co_phase_type;

endpackage : t2co_pkg

// ==== hdl/t2co_prescale.sv ====
// Peripheral clock prescaler: one-cycle tick per peripheral-clock cycle pair.
// Assumes clk_sys is the oscillator clock, inputs synchronous.
`timescale 1ns/10ps
`include "t2co_regs.svh"

module t2co_prescale #(
  parameter int STD_PERIODS = `T2CO_PER_STD,
  parameter int FAST_PERIODS = `T2CO_PER_FAST,
  parameter int INC_DIV = `T2CO_INC_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic double_speed_mode,
  input wire logic fast_select,
  // Tick
  output logic tick
);

  localparam int CW = 6;
  localparam logic [CW-1:0] STD_LAST = CW'(STD_PERIODS * INC_DIV - 1);
  localparam logic [CW-1:0] FAST_LAST = CW'(FAST_PERIODS * INC_DIV - 1);

  t2co_pkg::t2co_phase_type phase_reg;
  t2co_pkg::t2co_phase_type phase_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [CW-1:0] last;

  // ****************************************
  // Divider
  // ****************************************
  always_comb begin
    last = (double_speed_mode && fast_select) ? FAST_LAST : STD_LAST;
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    tick = 1'b0;
    case (phase_reg)
      t2co_pkg::T2CO_PH_IDLE: begin
        cnt_next = '0;
        if (enable) begin
          phase_next = t2co_pkg::T2CO_PH_RUN;
        end
      end
      t2co_pkg::T2CO_PH_RUN: begin
        if (!enable) begin
          phase_next = t2co_pkg::T2CO_PH_IDLE;
        end else if (cnt_reg >= last) begin
          tick = 1'b1;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: begin
        phase_next = t2co_pkg::T2CO_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_reg <= t2co_pkg::T2CO_PH_IDLE;
      cnt_reg <= '0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
    end
  end

  // Period is 24 or 12 oscillator cycles
  AST_TICK_SPACING: assert property (@(posedge clk_sys) disable iff (rst)
    tick |=> !tick [*5])
    else $error("Prescaler ticks too close");

endmodule : t2co_prescale

// ==== hdl/t2co_regs.svh ====
// Register offsets, field positions, reset values and timing counts for the clock-out timer.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef T2CO_REGS_SVH
`define T2CO_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define T2CO_OFF_CONTROL 12'h000
`define T2CO_OFF_MODE 12'h004
`define T2CO_OFF_RELOAD_LOW 12'h008
`define T2CO_OFF_RELOAD_HIGH 12'h00C
`define T2CO_OFF_COUNT_LOW 12'h010
`define T2CO_OFF_COUNT_HIGH 12'h014
`define T2CO_OFF_SPEED 12'h018
`define T2CO_OFF_STATUS 12'h01C

// ****************************************
// Field positions
// ****************************************
`define T2CO_CTL_RUN_BIT 2
`define T2CO_CTL_TCSEL_BIT 1
`define T2CO_MODE_OE_BIT 1
`define T2CO_SPD_DOUBLE_BIT 0
`define T2CO_SPD_FAST_BIT 1
`define T2CO_STS_CLK_BIT 0
`define T2CO_STS_RUN_BIT 1
`define T2CO_STS_TICK_BIT 2

// ****************************************
// Reset values
// ****************************************
`define T2CO_RST_BYTE 8'h00

// ****************************************
// Timing counts: oscillator periods per peripheral clock, and peripheral clocks per count step
// ****************************************
`define T2CO_PER_STD 12
`define T2CO_PER_FAST 6
`define T2CO_INC_DIV 2

`endif

// ==== hdl/t2co_top.sv ====
// Clock-out timer: 16-bit auto-reload counter toggling a pin at each overflow.
// Assumes an APB master on clk_sys and a pad that resolves the pin enables.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "t2co_regs.svh"

// Contract
// - Clock-out output has 50% duty cycle
// - Low byte increments at half peripheral rate
// - Overflow reloads count from reload pair
// - Overflow raises no interrupt request
// - Frequency is Fperiph over 4x(65536-reload)
// - Clock drives timer external pin
// - Counting starts only on run control
// - Reload shared with baud generator use
// - Peripheral clock 12 or 6 oscillator periods
// - Fast speed only in double speed
module t2co_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer external pin, shared with general-purpose port bit 0
  input wire logic timer_external_pin_in,
  output logic timer_external_pin_out,
  output logic timer_external_pin_oe_n,
  input wire logic port_bit0_out,
  // Shared overflow for a baud generator
  output logic overflow_tick
);

  logic [7:0] timer_count_low_reg, timer_count_low_next;
  logic [7:0] timer_count_high_reg, timer_count_high_next;
  logic [7:0] reload_value_low_reg, reload_value_low_next;
  logic [7:0] reload_value_high_reg, reload_value_high_next;
  logic run_control_reg, run_control_next;
  logic timer_counter_select_reg, timer_counter_select_next;
  logic clock_output_enable_reg, clock_output_enable_next;
  logic double_speed_mode_reg, double_speed_mode_next;
  logic fast_select_reg, fast_select_next;
  logic clk_out_reg, clk_out_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pin_prev_reg, pin_prev_next;
  logic tick;
  logic count_evt;
  logic [15:0] count;
  logic [15:0] count_inc;
  logic ovf;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic run_clock;

  // ****************************************
  // Peripheral clock prescaler
  // ****************************************
  // Prescaler only runs while started
  assign run_clock = run_control_reg && !timer_counter_select_reg;

  t2co_prescale #(
    .STD_PERIODS(`T2CO_PER_STD),
    .FAST_PERIODS(`T2CO_PER_FAST),
    .INC_DIV(`T2CO_INC_DIV)
  ) u_prescale (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(run_clock),
    .double_speed_mode(double_speed_mode_reg),
    .fast_select(fast_select_reg),
    .tick(tick)
  );

  // ****************************************
  // APB decode
  // ****************************************
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      `T2CO_OFF_CONTROL, `T2CO_OFF_MODE, `T2CO_OFF_RELOAD_LOW, `T2CO_OFF_RELOAD_HIGH,
      `T2CO_OFF_COUNT_LOW, `T2CO_OFF_COUNT_HIGH, `T2CO_OFF_SPEED, `T2CO_OFF_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  // Unmapped access is flagged but harmless
  assign pslverr = psel && penable && !addr_ok;

  // ****************************************
  // Counter
  // ****************************************
  // External-event counting kept for counter mode; edge on the pin input
  assign count_evt = run_control_reg && (timer_counter_select_reg ? (pin_prev_reg && !timer_external_pin_in) : tick);
  assign count = {timer_count_high_reg, timer_count_low_reg};
  assign count_inc = count + 16'h0001;
  assign ovf = count_evt && (count == 16'hFFFF);
  // Overflow exported for a baud user
  assign overflow_tick = ovf;

  always_comb begin
    timer_count_low_next = timer_count_low_reg;
    timer_count_high_next = timer_count_high_reg;
    reload_value_low_next = reload_value_low_reg;
    reload_value_high_next = reload_value_high_reg;
    run_control_next = run_control_reg;
    timer_counter_select_next = timer_counter_select_reg;
    clock_output_enable_next = clock_output_enable_reg;
    double_speed_mode_next = double_speed_mode_reg;
    fast_select_next = fast_select_reg;
    clk_out_next = clk_out_reg;
    pin_prev_next = timer_external_pin_in;
    // No event means count and output hold
    if (ovf) begin
      timer_count_low_next = reload_value_low_reg;
      timer_count_high_next = reload_value_high_reg;
      clk_out_next = !clk_out_reg;
    end else if (count_evt) begin
      timer_count_low_next = count_inc[7:0];
      timer_count_high_next = count_inc[15:8];
    end
    // Software writes land after the counter step
    if (wr_en) begin
      case (paddr)
        `T2CO_OFF_CONTROL: begin
          run_control_next = pwdata[`T2CO_CTL_RUN_BIT];
          timer_counter_select_next = pwdata[`T2CO_CTL_TCSEL_BIT];
        end
        `T2CO_OFF_MODE: clock_output_enable_next = pwdata[`T2CO_MODE_OE_BIT];
        `T2CO_OFF_RELOAD_LOW: reload_value_low_next = pwdata[7:0];
        `T2CO_OFF_RELOAD_HIGH: reload_value_high_next = pwdata[7:0];
        `T2CO_OFF_COUNT_LOW: timer_count_low_next = pwdata[7:0];
        `T2CO_OFF_COUNT_HIGH: timer_count_high_next = pwdata[7:0];
        `T2CO_OFF_SPEED: begin
          double_speed_mode_next = pwdata[`T2CO_SPD_DOUBLE_BIT];
          fast_select_next = pwdata[`T2CO_SPD_FAST_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    prdata_next = prdata_reg;
    if (rd_en) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        `T2CO_OFF_CONTROL: begin
          prdata_next[`T2CO_CTL_RUN_BIT] = run_control_reg;
          prdata_next[`T2CO_CTL_TCSEL_BIT] = timer_counter_select_reg;
        end
        `T2CO_OFF_MODE: prdata_next[`T2CO_MODE_OE_BIT] = clock_output_enable_reg;
        `T2CO_OFF_RELOAD_LOW: prdata_next[7:0] = reload_value_low_reg;
        `T2CO_OFF_RELOAD_HIGH: prdata_next[7:0] = reload_value_high_reg;
        `T2CO_OFF_COUNT_LOW: prdata_next[7:0] = timer_count_low_reg;
        `T2CO_OFF_COUNT_HIGH: prdata_next[7:0] = timer_count_high_reg;
        `T2CO_OFF_SPEED: begin
          prdata_next[`T2CO_SPD_DOUBLE_BIT] = double_speed_mode_reg;
          prdata_next[`T2CO_SPD_FAST_BIT] = fast_select_reg;
        end
        `T2CO_OFF_STATUS: begin
          prdata_next[`T2CO_STS_CLK_BIT] = clk_out_reg;
          prdata_next[`T2CO_STS_RUN_BIT] = run_clock;
          prdata_next[`T2CO_STS_TICK_BIT] = tick;
        end
        default: begin
        end
      endcase
    end
  end
  assign prdata = prdata_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_count_low_reg <= `T2CO_RST_BYTE;
      timer_count_high_reg <= `T2CO_RST_BYTE;
      reload_value_low_reg <= `T2CO_RST_BYTE;
      reload_value_high_reg <= `T2CO_RST_BYTE;
      run_control_reg <= 1'b0;
      timer_counter_select_reg <= 1'b0;
      clock_output_enable_reg <= 1'b0;
      double_speed_mode_reg <= 1'b0;
      fast_select_reg <= 1'b0;
      clk_out_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pin_prev_reg <= 1'b1;
    end else begin
      timer_count_low_reg <= timer_count_low_next;
      timer_count_high_reg <= timer_count_high_next;
      reload_value_low_reg <= reload_value_low_next;
      reload_value_high_reg <= reload_value_high_next;
      run_control_reg <= run_control_next;
      timer_counter_select_reg <= timer_counter_select_next;
      clock_output_enable_reg <= clock_output_enable_next;
      double_speed_mode_reg <= double_speed_mode_next;
      fast_select_reg <= fast_select_next;
      clk_out_reg <= clk_out_next;
      prdata_reg <= prdata_next;
      pin_prev_reg <= pin_prev_next;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Clock out replaces port bit 0 when enabled and not in counter mode
  assign timer_external_pin_out = (clock_output_enable_reg && !timer_counter_select_reg) ? clk_out_reg : port_bit0_out;
  // Open-drain style port: drive low only, clock-out drives both levels
  assign timer_external_pin_oe_n = (clock_output_enable_reg && !timer_counter_select_reg) ? 1'b0 : port_bit0_out;

  // ****************************************
  // Checks
  // ****************************************
  // Events per half period
  logic [16:0] gap_reg, gap_next;
  logic gap_valid_reg, gap_valid_next;

  // Any write may move count or reload, so it voids the measure
  always_comb begin
    gap_next = gap_reg;
    gap_valid_next = gap_valid_reg && !wr_en;
    if (ovf) begin
      gap_next = 17'h00000;
      gap_valid_next = !wr_en;
    end else if (count_evt) begin
      gap_next = gap_reg + 17'h00001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gap_reg <= 17'h00000;
      gap_valid_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      gap_valid_reg <= gap_valid_next;
    end
  end

  AST_RELOAD: assert property (@(posedge clk_sys) disable iff (rst)
    (ovf && !wr_en) |=> count == {$past(reload_value_high_reg), $past(reload_value_low_reg)})
    else $error("Count not reloaded at overflow");

  AST_TOGGLE: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(clk_out_reg) |-> $past(ovf))
    else $error("Clock output changed without overflow");

  AST_DUTY: assert property (@(posedge clk_sys) disable iff (rst)
    ovf |=> clk_out_reg != $past(clk_out_reg))
    else $error("Clock output missed a half period");

  AST_STOPPED: assert property (@(posedge clk_sys) disable iff (rst)
    (!run_control_reg && !wr_en) |=> $stable(count))
    else $error("Count moved while stopped");

  AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    !run_control_reg |=> $stable(clk_out_reg))
    else $error("Clock output moved while stopped");

  AST_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    (tick && !timer_counter_select_reg && count != 16'hFFFF && !wr_en) |=> count == $past(count) + 16'h0001)
    else $error("Counter step wrong");

  AST_NO_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
    overflow_tick |-> count == 16'hFFFF)
    else $error("Overflow pulse out of place");

  // Pin follows the clock when enabled and not in counter mode
  AST_PIN: assert property (@(posedge clk_sys) disable iff (rst)
    (clock_output_enable_reg && !timer_counter_select_reg) |-> timer_external_pin_out == clk_out_reg)
    else $error("Pin does not carry clock output");

  // Reload FFFF gives toggle every tick
  AST_FAST_RATE: assert property (@(posedge clk_sys) disable iff (rst)
    (count_evt && reload_value_high_reg == 8'hFF && reload_value_low_reg == 8'hFF && count == 16'hFFFF && !wr_en)
      |=> (count == 16'hFFFF && clk_out_reg != $past(clk_out_reg)))
    else $error("Overflow missing at top count");

  // Half period is 65536 minus reload
  AST_PERIOD: assert property (@(posedge clk_sys) disable iff (rst)
    (ovf && gap_valid_reg) |-> ((gap_reg + 17'h00001) == (17'h10000 - {1'b0, reload_value_high_reg, reload_value_low_reg})))
    else $error("Half period length wrong");

  COV_OVF: cover property (@(posedge clk_sys) disable iff (rst) ovf);
  COV_TWO_TOGGLES: cover property (@(posedge clk_sys) disable iff (rst) ovf ##[1:1000] ovf);
  COV_STOP_HOLD: cover property (@(posedge clk_sys) disable iff (rst) clk_out_reg && !run_control_reg);
  COV_FAST: cover property (@(posedge clk_sys) disable iff (rst) tick && double_speed_mode_reg && fast_select_reg);

endmodule : t2co_top

// ==== test/t2co_pin_monitor.sv ====
// Far-side clock receiver: measures phases at the timer pin.
// Assumes pin is the resolved pad level, sampled on clk_sys.
`timescale 1ns/10ps
module t2co_pin_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pad
  input wire logic pin,
  // Measurements
  output logic [15:0] edge_count,
  output logic [15:0] last_high,
  output logic [15:0] last_low
);
  logic [15:0] run_len;
  logic pin_d;
  // ****************************************
  // Phase widths
  // ****************************************
  // high and low widths
  always_ff @(posedge clk_sys) begin
    pin_d <= pin;
    if (rst) begin
      edge_count <= 16'h0000;
      run_len <= 16'h0000;
      last_high <= 16'h0000;
      last_low <= 16'h0000;
    end else if (pin != pin_d) begin
      edge_count <= edge_count + 16'h0001;
      run_len <= 16'h0001;
      if (pin_d) begin
        last_high <= run_len;
      end else begin
        last_low <= run_len;
      end
    end else begin
      run_len <= run_len + 16'h0001;
    end
  end
endmodule : t2co_pin_monitor

// ==== test/t2co_top_bench.sv ====
// Bench for the clock-out timer: APB tasks and pin timing checks.
// Assumes the pad has a pull-up while the pin is not driven.
`timescale 1ns/10ps
`include "t2co_regs.svh"
module t2co_top_bench;
  logic clk_sys, rst, psel, penable, pwrite, port_bit0_out, pslverr, pready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pin_out, pin_oe_n, ovf, er, p;
  logic [15:0] edges, hi_w, lo_w;
  wire logic pad;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int ovf_n = 0;
  int t0, o, e;
  // Pull-up on the pad when released
  assign pad = pin_oe_n ? 1'b1 : pin_out;
  t2co_top i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_external_pin_in(pad), .timer_external_pin_out(pin_out), .timer_external_pin_oe_n(pin_oe_n),
    .port_bit0_out(port_bit0_out), .overflow_tick(ovf));
  t2co_pin_monitor i_mon (.clk_sys(clk_sys), .rst(rst), .pin(pad), .edge_count(edges),
    .last_high(hi_w), .last_low(lo_w));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (ovf === 1'b1) ovf_n <= ovf_n + 1;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_edges(input int n);
    int x, t;
    x = edges + n;
    t = 0;
    while (edges !== x[15:0] && t < 4000) begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 4000) bad_count++;
  endtask : wait_edges
  // Half period in clk_sys cycles: two peripheral clocks per count
  function automatic logic [31:0] half(input int reload, input int div);
    return 32'((65536 - reload) * 2 * div);
  endfunction : half
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Longest test run is far below this span
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    port_bit0_out = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(12'(i * 4), 1'b0, 32'h00000000);
      check(rd, 32'h00000000);
    end
    apb(12'h020, 1'b0, 32'h00000000);
    check({31'h00000000, er}, 32'h00000001);
    for (int b = 0; b < 2; b++) begin
      port_bit0_out <= b[0];
      repeat (2) @(posedge clk_sys);
      check(32'(pad), 32'(b));
    end
    $display("Test reset done");
    apb(`T2CO_OFF_MODE, 1'b1, 32'h00000002);
    apb(`T2CO_OFF_CONTROL, 1'b1, 32'h00000000);
    apb(`T2CO_OFF_RELOAD_LOW, 1'b1, 32'h000000FE);
    apb(`T2CO_OFF_RELOAD_HIGH, 1'b1, 32'h000000FF);
    apb(`T2CO_OFF_COUNT_LOW, 1'b1, 32'h000000FF);
    apb(`T2CO_OFF_COUNT_HIGH, 1'b1, 32'h000000FF);
    e = edges;
    repeat (100) @(posedge clk_sys);
    check(32'(edges), 32'(e));
    check(32'(pin_oe_n), 32'h00000000);
    t0 = cyc;
    apb(`T2CO_OFF_CONTROL, 1'b1, 32'h00000004);
    wait_edges(1);
    check(32'(cyc - t0 < 40), 32'h00000001);
    o = ovf_n;
    wait_edges(2);
    check(32'(hi_w), half(32'hFFFE, 12));
    check(32'(lo_w), half(32'hFFFE, 12));
    check(32'(ovf_n - o), 32'h00000002);
    $display("Test clock-out done");
    // Reload change while running: only the low byte moves
    apb(`T2CO_OFF_RELOAD_LOW, 1'b1, 32'h000000FF);
    for (int s = 0; s < 4; s++) begin
      apb(`T2CO_OFF_SPEED, 1'b1, 32'(s));
      wait_edges(3);
      check(32'(hi_w), half(32'hFFFF, (s == 3) ? 6 : 12));
      check(32'(lo_w), half(32'hFFFF, (s == 3) ? 6 : 12));
    end
    $display("Test speed done");
    apb(`T2CO_OFF_CONTROL, 1'b1, 32'h00000000);
    // A toggle launched at the stop edge shows one cycle later
    repeat (2) @(posedge clk_sys);
    e = edges;
    p = pad;
    apb(`T2CO_OFF_COUNT_LOW, 1'b0, 32'h00000000);
    o = rd;
    repeat (300) @(posedge clk_sys);
    check(32'(edges), 32'(e));
    check(32'(pad), 32'(p));
    apb(`T2CO_OFF_COUNT_LOW, 1'b0, 32'h00000000);
    check(rd, 32'(o));
    apb(`T2CO_OFF_STATUS, 1'b0, 32'h00000000);
    check({31'h00000000, rd[`T2CO_STS_RUN_BIT]}, 32'h00000000);
    apb(`T2CO_OFF_CONTROL, 1'b1, 32'h00000004);
    wait_edges(3);
    check(32'(hi_w), half(32'hFFFF, 6));
    $display("Test stop done");
    apb(`T2CO_OFF_CONTROL, 1'b1, 32'h00000000);
    apb(`T2CO_OFF_COUNT_LOW, 1'b1, 32'h00000000);
    apb(`T2CO_OFF_COUNT_HIGH, 1'b1, 32'h00000000);
    apb(`T2CO_OFF_CONTROL, 1'b1, 32'h00000006);
    repeat (2) @(posedge clk_sys);
    check(32'(pad), 32'h00000001);
    for (int k = 0; k < 3; k++) begin
      port_bit0_out <= 1'b0;
      repeat (2) @(posedge clk_sys);
      port_bit0_out <= 1'b1;
      repeat (2) @(posedge clk_sys);
    end
    apb(`T2CO_OFF_COUNT_LOW, 1'b0, 32'h00000000);
    check(rd, 32'h00000003);
    $display("Test counter select done");
    stop_test();
  end
endmodule : t2co_top_bench
